// [bench/dppb_pipe_test.sv]
// Self-checking bench of the pipe: blend order, correction, scalers, FIFO flow
`timescale 1ns/100ps
module dppb_pipe_test;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic pix_valid = 1'b0;
    logic pix_ready;
    logic [6:0][31:0] plane_word = '0;
    logic [6:0] plane_en = '0;
    logic [6:0] plane_cc_en = '0;
    logic [9:0] plane_cc_offset = '0;
    logic [31:0] cursor_word = '0;
    logic cursor_en = 1'b0;
    dppb_pkg::dppb_pixel_t bg_color = 30'h2aaa_5555;
    logic [3:0] scl0_sel = 4'h0;
    logic [3:0] scl1_sel = 4'h0;
    dppb_pkg::dppb_cc_t out_cc = '0;
    logic lut3d_en = 1'b0;
    logic compress_en = 1'b0;
    logic out_valid;
    logic out_ready;
    dppb_pkg::dppb_pixel_t out_pixel;
    logic [9:0] lcs_peak;
    logic hold = 1'b0;
    logic got;
    dppb_pkg::dppb_pixel_t got_pixel;
    logic [30:0] exp_q[$];
    logic [9:0] peak = '0;
    int rx = 0;
    int err_total = 0;
    int checked = 0;

    always #4 ref_clk = ~ref_clk;

    dppb_pipe #(.FIRST_PIPE(1'b1), .FIFO_DEPTH(16)) u_dppb_pipe (
        .REF_CLK(ref_clk), .RST(rst), .CE(ce), .PIX_VALID(pix_valid),
        .PIX_READY(pix_ready), .PLANE_WORD(plane_word), .PLANE_EN(plane_en),
        .PLANE_CC_EN(plane_cc_en), .PLANE_CC_OFFSET(plane_cc_offset),
        .CURSOR_WORD(cursor_word), .CURSOR_EN(cursor_en), .BG_COLOR(bg_color),
        .SCL0_SEL(scl0_sel), .SCL1_SEL(scl1_sel), .OUT_CC(out_cc), .COMPRESS_EN(compress_en),
        .LUT3D_EN(lut3d_en), .OUT_VALID(out_valid), .OUT_READY(out_ready),
        .OUT_PIXEL(out_pixel), .LCS_PEAK(lcs_peak));
    dppb_sink u_dppb_sink (.clk(ref_clk), .ce(ce), .hold(hold), .out_valid(out_valid),
        .out_ready(out_ready), .out_pixel(out_pixel), .got(got), .got_pixel(got_pixel));

    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic bail(input string what);
        check(what, 0, 1);
        end_of_test();
    endtask

    function automatic logic [29:0] add_sat(input logic [29:0] p, input logic [9:0] o);
        logic [10:0] s;
        for (int c = 0; c < 30; c += 10) begin
            s = p[c +: 10] + o;
            p[c +: 10] = s[10] ? dppb_pkg::CHAN_MAX : s[9:0];
        end
        return p;
    endfunction

    // Reference pixel from the inputs as they stand now
    function automatic logic [29:0] expect_pix();
        logic [29:0] p;
        logic [29:0] q;
        logic [31:0] w;
        p = bg_color;
        for (int i = 0; i < dppb_pkg::NUM_PLANES; i++) begin
            w = plane_word[i];
            q = (i < dppb_pkg::NUM_HDR_PLANES) ? w[29:0]
                : {w[23:16], w[23:22], w[15:8], w[15:14], w[7:0], w[7:6]};
            if (plane_cc_en[i]) q = add_sat(q, plane_cc_offset);
            if (plane_en[i] && w[30]) p = q;
        end
        if (cursor_en && cursor_word[30]) p = cursor_word[29:0];
        if (out_cc.en && out_cc.cc_en) p = add_sat(p, out_cc.cc_offset);
        return lut3d_en ? ~p : p;
    endfunction

    // Pixels come out in the order beats went in
    always @(negedge ref_clk) begin
        if (got === 1'b1) begin
            rx++;
            if (exp_q.size() == 0) begin
                check("extra pixel", 1, 0);
            end else begin
                if (exp_q[0][30]) check("pixel", got_pixel, exp_q[0][29:0]);
                void'(exp_q.pop_front());
            end
            if (got_pixel.g > peak) peak = got_pixel.g;
        end
    end

    task automatic offer(input bit chk);
        int n;
        n = 0;
        pix_valid <= 1'b1;
        @(negedge ref_clk);
        while (!(pix_ready === 1'b1 && ce === 1'b1)) begin
            if (++n > 200) bail("input stuck");
            @(negedge ref_clk);
        end
        exp_q.push_back({chk, expect_pix()});
        @(posedge ref_clk);
    endtask

    task automatic drain();
        int n;
        n = 0;
        pix_valid <= 1'b0;
        while (exp_q.size() != 0) begin
            if (++n > 300) bail("output stuck");
            @(negedge ref_clk);
        end
        @(posedge ref_clk);
    endtask

    // Config is sampled live, so each beat drains before the next change
    task automatic one();
        offer(1'b1);
        drain();
    endtask

    ////////////////////////////////////////
    task automatic t_reset();
        @(negedge ref_clk);
        check("ready after reset", pix_ready, 1);
        check("valid after reset", out_valid, 0);
        check("peak after reset", lcs_peak, 0);
        @(posedge ref_clk);
    endtask

    task automatic t_stack();
        logic [6:0] masks[8] = '{7'h00, 7'h01, 7'h03, 7'h05, 7'h40, 7'h3e, 7'h7b, 7'h7f};
        for (int i = 0; i < 7; i++) plane_word[i] <= {2'b01, 30'(32'h1357_9bdf * (i + 1))};
        foreach (masks[k]) begin
            plane_en <= masks[k];
            one();
        end
        plane_word[6][30] <= 1'b0;
        one();
    endtask

    task automatic t_cursor();
        for (int k = 0; k < 3; k++) begin
            cursor_en <= (k != 2);
            cursor_word <= {1'b0, k != 1, 30'h1234_5678};
            one();
        end
        cursor_en <= 1'b0;
    endtask

    task automatic t_color();
        plane_cc_offset <= 10'h3f0;
        plane_cc_en <= 7'h61;
        plane_en <= 7'h01;
        one();
        plane_en <= 7'h7f;
        one();
        plane_cc_en <= 7'h00;
        out_cc <= '{1'b1, 1'b0, 10'h155};
        one();
        out_cc.cc_en <= 1'b1;
        one();
        out_cc <= '0;
        lut3d_en <= 1'b1;
        one();
        lut3d_en <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check("peak", lcs_peak, peak);
        @(posedge ref_clk);
    endtask

    // Twin equal beats: the second must pass any scaler unchanged
    task automatic t_scaler();
        plane_en <= 7'h01;
        for (int c = 0; c < 10; c++) begin
            scl0_sel <= c[3:0];
            scl1_sel <= 4'(9 - c);
            offer(1'b0);
            offer(1'b1);
            drain();
        end
        scl0_sel <= 4'h0;
        scl1_sel <= 4'h0;
    endtask

    // A repeat-flagged plane 1 word must show the previous decoded pixel
    task automatic t_compress();
        logic [29:0] keep;
        keep = plane_word[0][29:0];
        plane_en <= 7'h01;
        compress_en <= 1'b1;
        plane_word[0] <= {2'b11, 30'h0000_0000};
        pix_valid <= 1'b1;
        @(negedge ref_clk);
        check("ready before repeat", pix_ready, 1);
        exp_q.push_back({1'b1, keep});
        @(posedge ref_clk);
        drain();
        compress_en <= 1'b0;
        plane_word[0] <= {2'b01, keep};
    endtask

    task automatic t_fifo();
        int n;
        int r0;
        hold <= 1'b1;
        pix_valid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            plane_word[0] <= {2'b01, 30'(n * 32'h0010_0401)};
            @(negedge ref_clk);
            if (pix_ready !== 1'b1) break;
            exp_q.push_back({1'b1, expect_pix()});
            @(posedge ref_clk);
        end
        check("beats before full", n >= 16, 1);
        repeat (4) @(negedge ref_clk);
        check("ready while full", pix_ready, 0);
        @(posedge ref_clk);
        pix_valid <= 1'b0;
        ce <= 1'b0;
        hold <= 1'b0;
        r0 = rx;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        check("pops while frozen", rx, r0);
        check("valid while frozen", out_valid, 1);
        @(posedge ref_clk);
        ce <= 1'b1;
        drain();
        @(negedge ref_clk);
        check("valid when empty", out_valid, 0);
        check("ready when empty", pix_ready, 1);
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_stack();
        t_cursor();
        t_color();
        t_scaler();
        t_compress();
        t_fifo();
        end_of_test();
    end
endmodule

// [bench/dppb_sink.sv]
// Transcoder stand-in: takes finished pixels and stalls on request
`timescale 1ns/100ps
module dppb_sink (
    input wire logic clk, // Pixel clock
    input wire logic ce, // Pipe clock enable
    input wire logic hold, // Stall request
    input wire logic out_valid, // Pixel offered
    output logic out_ready, // Ready to take
    input wire dppb_pkg::dppb_pixel_t out_pixel, // Offered pixel
    output logic got, // Pixel taken at last edge
    output dppb_pkg::dppb_pixel_t got_pixel // Pixel taken
);
    // A plain level, so a stall may start on any cycle
    assign out_ready = !hold;
    always_ff @(posedge clk) begin
        got <= ce && out_valid && out_ready;
        got_pixel <= out_pixel;
    end
endmodule

// [logic/dppb_pipe.sv]
// One display pipe: plane fetch conversion, fixed-order blend, scalers, colour correction
`timescale 1ns/100ps
// Function
// [R1] Seven planes plus one cursor feed blending
// [R2] Fixed order: higher planes over lower
// [R3] Cursor always sits above all planes
// [R4] Programmable background under the lowest plane
// [R5] Planes 1-3 HDR, planes 4-7 SDR
// [R6] Two scalers, each on plane or blend
// [R7] Planes fetch, convert, optionally correct and scale
// [R8] Blend passes colour correction before transcoder
// [R9] Compressor, 3D LUT, statistics on first pipe
// [R10] Disabled plane contributes nothing to blend

////////////////////////////////////////////////////////////////////////////////
module dppb_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 16
) (
    input wire logic clk,               // Pixel clock
    input wire logic rst,               // Async reset, high
    input wire logic ce,                // Clock enable
    input wire logic in_valid,          // Write request
    output logic in_ready,              // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Write word
    output logic out_valid,             // Head word present
    input wire logic out_ready,         // Sink takes head
    output logic [WIDTH-1:0] out_data   // Head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic rdy_reg, rdy_next, val_reg, val_next;
    logic push, pop;

    always_comb begin
        push = ce && in_valid && rdy_reg;
        pop = ce && out_ready && val_reg;
        wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next = (AW+1)'(cnt_reg + (AW+1)'(push) - (AW+1)'(pop));
        rdy_next = cnt_next < (AW+1)'(DEPTH);
        val_next = cnt_next != '0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            rdy_reg <= 1'b1;
            val_reg <= 1'b0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
            rdy_reg <= rdy_next;
            val_reg <= val_next;
        end
    end

    // Storage needs no reset; only words below the count are ever shown
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    assign in_ready = rdy_reg;
    assign out_valid = val_reg;
    assign out_data = mem_reg[rd_reg];
endmodule

////////////////////////////////////////////////////////////////////////////////
module dppb_pipe #(
    parameter bit FIRST_PIPE = 1'b1,
    parameter int FIFO_DEPTH = dppb_pkg::FIFO_DEPTH
) (
    input wire logic REF_CLK,                                   // Pixel clock, 125 MHz
    input wire logic RST,                                       // Async reset, high
    input wire logic CE,                                        // Clock enable
    input wire logic PIX_VALID,                                 // Layer beat offered
    output logic PIX_READY,                                     // Beat can be taken
    input wire logic [dppb_pkg::NUM_PLANES-1:0][31:0] PLANE_WORD, // Fetched plane words
    input wire logic [dppb_pkg::NUM_PLANES-1:0] PLANE_EN,       // Plane enables
    input wire logic [dppb_pkg::NUM_PLANES-1:0] PLANE_CC_EN,    // Plane colour correction
    input wire logic [9:0] PLANE_CC_OFFSET,                     // Plane correction offset
    input wire logic [31:0] CURSOR_WORD,                        // Cursor pixel word
    input wire logic CURSOR_EN,                                 // Cursor enable
    input wire dppb_pkg::dppb_pixel_t BG_COLOR,                 // Background colour
    input wire logic [3:0] SCL0_SEL,                            // Scaler 0 attachment
    input wire logic [3:0] SCL1_SEL,                            // Scaler 1 attachment
    input wire dppb_pkg::dppb_cc_t OUT_CC,                      // Output correction
    input wire logic COMPRESS_EN,                               // Plane 1 decompression
    input wire logic LUT3D_EN,                                  // 3D LUT stage enable
    output logic OUT_VALID,                                     // Pixel to transcoder
    input wire logic OUT_READY,                                 // Transcoder takes pixel
    output dppb_pkg::dppb_pixel_t OUT_PIXEL,                    // Finished pixel
    output logic [9:0] LCS_PEAK                                 // Contrast statistics peak
);
    localparam int NP = dppb_pkg::NUM_PLANES;
    typedef dppb_pkg::dppb_pixel_t px_t;

    function automatic px_t px_add(px_t a, logic [9:0] off);
        logic [10:0] r, g, b;
        r = {1'b0, a.r} + {1'b0, off};
        g = {1'b0, a.g} + {1'b0, off};
        b = {1'b0, a.b} + {1'b0, off};
        return '{r[10] ? dppb_pkg::CHAN_MAX : r[9:0], g[10] ? dppb_pkg::CHAN_MAX : g[9:0],
                 b[10] ? dppb_pkg::CHAN_MAX : b[9:0]};
    endfunction

    // Two-tap horizontal filter; keeps one pixel out per pixel in
    function automatic px_t px_avg(px_t a, px_t c);
        logic [10:0] r, g, b;
        r = {1'b0, a.r} + {1'b0, c.r};
        g = {1'b0, a.g} + {1'b0, c.g};
        b = {1'b0, a.b} + {1'b0, c.b};
        return '{r[10:1], g[10:1], b[10:1]};
    endfunction

    logic adv, fifo_ready;
    assign adv = CE && fifo_ready; // Whole pipe stalls on back-pressure

    ////////////////////////////////////////////////////////////////////////////////
    // Stage 1: per-plane conversion, correction and scaling
    px_t conv [NP];
    px_t l1_reg [NP], l1_next [NP], prev_reg [NP], prev_next [NP];
    logic [NP-1:0] op1_reg, op1_next;
    px_t cur1_reg, cur1_next;
    logic curop1_reg, curop1_next, v1_reg, v1_next;

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_plane
            always_comb begin
                if (p < dppb_pkg::NUM_HDR_PLANES) begin
                    conv[p] = px_t'(PLANE_WORD[p][29:0]); // [R5]
                end else begin
                    conv[p] = '{{PLANE_WORD[p][23:16], PLANE_WORD[p][23:22]},
                                {PLANE_WORD[p][15:8], PLANE_WORD[p][15:14]},
                                {PLANE_WORD[p][7:0], PLANE_WORD[p][7:6]}}; // [R5]
                end
                // Compressed runs repeat the previous decoded pixel of plane 1
                if (p == 0 && FIRST_PIPE && COMPRESS_EN && PLANE_WORD[p][dppb_pkg::REPEAT_BIT]) begin
                    conv[p] = prev_reg[p]; // [R9]
                end
                l1_next[p] = l1_reg[p];
                prev_next[p] = prev_reg[p];
                op1_next[p] = op1_reg[p];
                if (adv && PIX_VALID) begin
                    prev_next[p] = conv[p];
                    l1_next[p] = PLANE_CC_EN[p] ? px_add(conv[p], PLANE_CC_OFFSET) : conv[p]; // [R7]
                    if (SCL0_SEL == 4'(p + 1) || SCL1_SEL == 4'(p + 1)) begin
                        l1_next[p] = px_avg(l1_next[p], prev_reg[p]); // [R6] [R7]
                    end
                    op1_next[p] = PLANE_EN[p] && PLANE_WORD[p][dppb_pkg::OPAQUE_BIT]; // [R10]
                end
            end
        end
    endgenerate

    always_comb begin
        cur1_next = cur1_reg;
        curop1_next = curop1_reg;
        v1_next = v1_reg;
        if (adv) begin
            v1_next = PIX_VALID;
            if (PIX_VALID) begin
                cur1_next = px_t'(CURSOR_WORD[29:0]);
                curop1_next = CURSOR_EN && CURSOR_WORD[dppb_pkg::OPAQUE_BIT];
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < NP; i++) begin
                l1_reg[i] <= '0;
                prev_reg[i] <= '0;
            end
            op1_reg <= '0;
            cur1_reg <= '0;
            curop1_reg <= 1'b0;
            v1_reg <= 1'b0;
        end else begin
            l1_reg <= l1_next;
            prev_reg <= prev_next;
            op1_reg <= op1_next;
            cur1_reg <= cur1_next;
            curop1_reg <= curop1_next;
            v1_reg <= v1_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stage 2: blend from the background upward, cursor last
    px_t blend_reg, blend_next;
    logic v2_reg, v2_next;

    always_comb begin
        blend_next = blend_reg;
        v2_next = v2_reg;
        if (adv) begin
            v2_next = v1_reg;
            blend_next = BG_COLOR; // [R4]
            for (int i = 0; i < NP; i++) begin
                if (op1_reg[i]) begin
                    blend_next = l1_reg[i]; // [R1] [R2] [R10]
                end
            end
            if (curop1_reg) begin
                blend_next = cur1_reg; // [R3]
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            blend_reg <= '0;
            v2_reg <= 1'b0;
        end else begin
            blend_reg <= blend_next;
            v2_reg <= v2_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stage 3: output scaler, colour correction, 3D LUT, statistics
    px_t post_reg, post_next, pout_reg, pout_next, t;
    logic v3_reg, v3_next;
    logic [9:0] lcs_reg, lcs_next;

    always_comb begin
        post_next = post_reg;
        pout_next = pout_reg;
        v3_next = v3_reg;
        lcs_next = lcs_reg;
        t = blend_reg;
        if (SCL0_SEL == dppb_pkg::SCL_BLEND || SCL1_SEL == dppb_pkg::SCL_BLEND) begin
            t = px_avg(blend_reg, pout_reg); // [R6]
        end
        if (OUT_CC.en && OUT_CC.cc_en) begin
            t = px_add(t, OUT_CC.cc_offset); // [R8]
        end
        // Inverting stand-in for the 3D LUT; absent from later pipes
        if (FIRST_PIPE && LUT3D_EN) begin
            t = ~t; // [R9]
        end
        if (adv) begin
            v3_next = v2_reg;
            if (v2_reg) begin
                pout_next = blend_reg;
                post_next = t; // [R8]
                if (FIRST_PIPE && t.g > lcs_reg) begin
                    lcs_next = t.g; // [R9]
                end
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            post_reg <= '0;
            pout_reg <= '0;
            v3_reg <= 1'b0;
            lcs_reg <= '0;
        end else begin
            post_reg <= post_next;
            pout_reg <= pout_next;
            v3_reg <= v3_next;
            lcs_reg <= lcs_next;
        end
    end

    assign LCS_PEAK = lcs_reg;

    dppb_fifo #(.WIDTH($bits(px_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(REF_CLK),
        .rst(RST),
        .ce(CE),
        .in_valid(v3_reg && fifo_ready),
        .in_ready(fifo_ready),
        .in_data(post_reg),
        .out_valid(OUT_VALID),
        .out_ready(OUT_READY),
        .out_data(OUT_PIXEL)
    );
    assign PIX_READY = fifo_ready;

    ////////////////////////////////////////////////////////////////////////////////
    property p_cursor_top;
        @(posedge REF_CLK) disable iff (RST)
        adv && curop1_reg |=> blend_reg == $past(cur1_reg);
    endproperty
    a_cursor_top: assert property (p_cursor_top) else $error("cursor not on top"); // [R3]

    property p_background;
        @(posedge REF_CLK) disable iff (RST)
        adv && !curop1_reg && op1_reg == '0 |=> blend_reg == $past(BG_COLOR);
    endproperty
    a_background: assert property (p_background) else $error("background lost"); // [R4]

    property p_top_plane;
        @(posedge REF_CLK) disable iff (RST)
        adv && !curop1_reg && op1_reg[NP-1] |=> blend_reg == $past(l1_reg[NP-1]);
    endproperty
    a_top_plane: assert property (p_top_plane) else $error("stack order wrong"); // [R2]

    property p_disabled;
        @(posedge REF_CLK) disable iff (RST)
        adv && PIX_VALID && !PLANE_EN[0] |=> !op1_reg[0];
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled plane shown"); // [R10]

    property p_sdr_expand;
        @(posedge REF_CLK) disable iff (RST)
        adv && PIX_VALID && !PLANE_CC_EN[3] && SCL0_SEL != 4'h4 && SCL1_SEL != 4'h4
            |=> l1_reg[3].r[1:0] == l1_reg[3].r[9:8];
    endproperty
    a_sdr_expand: assert property (p_sdr_expand) else $error("SDR expansion wrong"); // [R5]

    property p_pass_post;
        @(posedge REF_CLK) disable iff (RST)
        adv && v2_reg && !OUT_CC.en && !LUT3D_EN && SCL0_SEL != dppb_pkg::SCL_BLEND
            && SCL1_SEL != dppb_pkg::SCL_BLEND |=> post_reg == $past(blend_reg) && v3_reg;
    endproperty
    a_pass_post: assert property (p_pass_post) else $error("post path altered pixel"); // [R8]

    property p_out_scale;
        @(posedge REF_CLK) disable iff (RST)
        adv && v2_reg && SCL0_SEL == dppb_pkg::SCL_BLEND && !OUT_CC.en && !LUT3D_EN
            |=> post_reg.g == 10'(({1'b0, $past(blend_reg.g)} + {1'b0, $past(pout_reg.g)}) >> 1);
    endproperty
    a_out_scale: assert property (p_out_scale) else $error("output scaler wrong"); // [R6]

    property p_first_only;
        @(posedge REF_CLK) disable iff (RST)
        !FIRST_PIPE |-> lcs_reg == '0;
    endproperty
    a_first_only: assert property (p_first_only) else $error("statistics on later pipe"); // [R9]

    property p_plane_cc;
        @(posedge REF_CLK) disable iff (RST)
        adv && PIX_VALID && PLANE_CC_EN[0] && !COMPRESS_EN && SCL0_SEL == dppb_pkg::SCL_OFF
            && SCL1_SEL == dppb_pkg::SCL_OFF |=> l1_reg[0].b >= $past(PLANE_WORD[0][9:0]);
    endproperty
    a_plane_cc: assert property (p_plane_cc) else $error("plane correction lost"); // [R7]
endmodule

// [logic/dppb_pkg.sv]
// Shared types and constants of the display pipe plane blender
package dppb_pkg;
    localparam int NUM_PLANES = 7;
    localparam int NUM_HDR_PLANES = 3;
    localparam int CHAN_W = 10;
    localparam int WORD_W = 32;
    localparam int FIFO_DEPTH = 16;
    // Memory word layout of a fetched pixel
    localparam int OPAQUE_BIT = 30;
    localparam int REPEAT_BIT = 31;
    localparam int SDR_CHAN_W = 8;
    // Scaler attachment codes: 1..7 pick a plane
    localparam logic [3:0] SCL_OFF = 4'h0;
    localparam logic [3:0] SCL_BLEND = 4'h8;
    localparam logic [CHAN_W-1:0] CHAN_MAX = 10'h3ff;

    typedef struct packed {
        logic [CHAN_W-1:0] r;
        logic [CHAN_W-1:0] g;
        logic [CHAN_W-1:0] b;
    } dppb_pixel_t;

    typedef struct packed {
        logic en;
        logic cc_en;
        logic [CHAN_W-1:0] cc_offset;
    } dppb_cc_t;
endpackage
